/* File: ptc_pkg.sv */
// package for the periodic timer pulse/capture block
package ptc_pkg;
  localparam int unsigned CNT_W = 10;

  // register byte addresses
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMPA_OFF = 8'h04;
  localparam logic [7:0] PER_OFF  = 8'h08;
  localparam logic [7:0] CNT_OFF  = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h10;

  // control field positions
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned ACT_LSB    = 2;
  localparam int unsigned RUN_BIT    = 4;
  localparam int unsigned CLRSEL_BIT = 5;
  localparam int unsigned OINIT_BIT  = 6;
  localparam int unsigned OPOL_BIT   = 7;
  localparam int unsigned SRC_LSB    = 8;

  // status bit positions
  localparam int unsigned STA_A_BIT = 0;
  localparam int unsigned STA_P_BIT = 1;

  // reset values
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [9:0] CMP_RST  = 10'h000;

  // mode and edge codes
  localparam logic [1:0] MODE_CAPT   = 2'h1;
  localparam logic [1:0] MODE_PULSE  = 2'h2;
  localparam logic [1:0] ACT_RISE    = 2'h0;
  localparam logic [1:0] ACT_FALL    = 2'h1;
  localparam logic [1:0] ACT_BOTH    = 2'h2;
  localparam logic [1:0] ACT_NONE    = 2'h3;
  localparam logic [1:0] SRC_PIN0    = 2'h0;
  localparam logic [1:0] SRC_PIN1    = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ptc_pkg

/* File: ptc_timer.sv */
// periodic timer with single-pulse output and input capture, AXI4-Lite regs
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
module ptc_timer
  import ptc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // timer tick and pins
  input  wire logic              tick,
  input  wire logic              ext_clock_pin,
  input  wire logic              capture_pin_zero,
  input  wire logic              capture_pin_one,
  output logic                   pulse_out,
  output logic                   timer_irq_a,
  output logic                   timer_irq_p,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  // write data
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // write response
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // read address
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  // read data
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready
);

  typedef enum logic [1:0] {
    PTC_OFF_MODE,
    PTC_PULSE_MODE,
    PTC_CAPT_MODE
  } ptc_mode_t;

  // state
  logic [9:0]       ctrl_q;
  logic [CNT_W-1:0] cmpa_q;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             run_q;
  logic             run_d;
  logic             ext_q;
  logic             p0_q;
  logic             p1_q;
  logic             cap_prev_q;
  logic             pulse_q;
  logic [1:0]       sta_q;

  // bus state
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              rvalid_q;
  logic [1:0]        bresp_q;
  logic              bvalid_q;

  function automatic logic edge_hit(input logic [1:0] act,
                                    input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    case (act)
      ACT_RISE: edge_hit = rise;
      ACT_FALL: edge_hit = fall;
      ACT_BOTH: edge_hit = rise || fall;
      default:  edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] off);
    addr_hit = (a == ADDR_W'(off));
  endfunction : addr_hit

  // mode decode
  wire logic [1:0] mode_f   = ctrl_q[MODE_LSB +: 2];
  wire logic [1:0] action_f = ctrl_q[ACT_LSB +: 2];
  wire logic [1:0] src_f    = ctrl_q[SRC_LSB +: 2];
  ptc_mode_t mode;
  always_comb begin
    if (mode_f == MODE_PULSE && action_f == ACT_NONE) begin
      mode = PTC_PULSE_MODE;
    end else if (mode_f == MODE_CAPT) begin
      mode = PTC_CAPT_MODE;
    end else begin
      mode = PTC_OFF_MODE;
    end
  end

  // write channel
  wire logic wr_go  = aw_have_q && w_have_q && !bvalid_q;
  wire logic wr_ctl = wr_go && addr_hit(awaddr_q, CTRL_OFF);
  wire logic wr_a   = wr_go && addr_hit(awaddr_q, CMPA_OFF);
  wire logic wr_p   = wr_go && addr_hit(awaddr_q, PER_OFF);
  wire logic wr_st  = wr_go && addr_hit(awaddr_q, STAT_OFF);
  wire logic wr_ok  = wr_ctl || wr_a || wr_p || wr_st
                      || addr_hit(awaddr_q, CNT_OFF);
  wire logic [9:0] wr_val = {wstrb_q[1] ? wdata_q[9:8] : 2'h0,
                             wstrb_q[0] ? wdata_q[7:0] : 8'h00};
  wire logic wr_lo = wstrb_q[0];
  wire logic [9:0] ctrl_new = {wstrb_q[1] ? wdata_q[9:8] : ctrl_q[9:8],
                               wr_lo ? wdata_q[7:0] : ctrl_q[7:0]};

  // pin edges; pin sampled directly, shared-output configuration ignored
  wire logic ext_edge = edge_hit(ACT_RISE, ext_q, ext_clock_pin);
  wire logic cap_pin  = (src_f == SRC_PIN0) ? capture_pin_zero :
                        (src_f == SRC_PIN1) ? capture_pin_one :
                        ext_clock_pin;
  wire logic cap_prev = (src_f == SRC_PIN0) ? p0_q :
                        (src_f == SRC_PIN1) ? p1_q : ext_q;
  wire logic cap_evt  = (mode == PTC_CAPT_MODE)
                        && edge_hit(action_f, cap_prev, cap_pin);
  wire logic unused_prev = cap_prev_q;

  // run bit: software value, pin trigger, compare A auto clear
  wire logic sw_run   = wr_ctl && wr_lo ? wdata_q[RUN_BIT] : run_q;
  wire logic pin_trig = (mode == PTC_PULSE_MODE) && ext_edge;
  wire logic run_rise = !run_q && run_d;
  wire logic match_a  = run_q && tick && (cnt_q == cmpa_q);
  wire logic match_p  = run_q && tick && (cnt_q == per_q)
                        && (per_q != '0);
  wire logic pulse_a  = (mode == PTC_PULSE_MODE) && match_a;

  always_comb begin
    run_d = sw_run || pin_trig;
    if (pulse_a) begin
      run_d = 1'b0;
    end
  end

  // counter: period only used in capture, clear-select unused
  always_comb begin
    cnt_d = cnt_q;
    if (run_rise) begin
      cnt_d = '0;
    end else if (run_q && tick) begin
      if (mode == PTC_CAPT_MODE && match_p) begin
        cnt_d = '0;
      end else begin
        cnt_d = CNT_W'(cnt_q + 1'b1);
      end
    end
  end

  wire logic irq_a_evt = pulse_a || cap_evt;
  wire logic irq_p_evt = (mode == PTC_CAPT_MODE) && match_p;

  // timer core
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q     <= CTRL_RST;
      cmpa_q     <= CMP_RST;
      per_q      <= CMP_RST;
      cnt_q      <= '0;
      run_q      <= 1'b0;
      ext_q      <= 1'b0;
      p0_q       <= 1'b0;
      p1_q       <= 1'b0;
      cap_prev_q <= 1'b0;
      pulse_q    <= 1'b0;
      sta_q      <= 2'h0;
    end else if (clk_en) begin
      ext_q      <= ext_clock_pin;
      p0_q       <= capture_pin_zero;
      p1_q       <= capture_pin_one;
      cap_prev_q <= cap_pin;
      run_q      <= run_d;
      cnt_q      <= cnt_d;
      if (wr_ctl) begin
        ctrl_q <= ctrl_new;
      end
      ctrl_q[RUN_BIT] <= run_d;
      if (cap_evt) begin
        cmpa_q <= cnt_q;
      end else if (wr_a) begin
        cmpa_q <= wr_val;
      end
      if (wr_p) begin
        per_q <= wr_val;
      end
      pulse_q <= (mode == PTC_PULSE_MODE) && run_d;
      // set wins over write-one-to-clear
      sta_q[STA_A_BIT] <= irq_a_evt
                       || (sta_q[STA_A_BIT] && !(wr_st && wr_val[STA_A_BIT]));
      sta_q[STA_P_BIT] <= irq_p_evt
                       || (sta_q[STA_P_BIT] && !(wr_st && wr_val[STA_P_BIT]));
    end
  end

  assign pulse_out   = pulse_q;
  assign timer_irq_a = sta_q[STA_A_BIT];
  assign timer_irq_p = sta_q[STA_P_BIT];

  // axi4-lite slave
  wire logic aw_take = s_awvalid && s_awready;
  wire logic w_take  = s_wvalid && s_wready;
  wire logic ar_take = s_arvalid && s_arready;
  assign s_awready = !aw_have_q;
  assign s_wready  = !w_have_q;
  assign s_arready = !rvalid_q;

  wire logic [31:0] rd_mux =
    addr_hit(s_araddr, CTRL_OFF) ? {22'h0, ctrl_q} :
    addr_hit(s_araddr, CMPA_OFF) ? {22'h0, cmpa_q} :
    addr_hit(s_araddr, PER_OFF)  ? {22'h0, per_q}  :
    addr_hit(s_araddr, CNT_OFF)  ? {22'h0, cnt_q}  :
    addr_hit(s_araddr, STAT_OFF) ? {30'h0, sta_q}  : 32'h0;
  wire logic rd_ok = addr_hit(s_araddr, CTRL_OFF)
                     || addr_hit(s_araddr, CMPA_OFF)
                     || addr_hit(s_araddr, PER_OFF)
                     || addr_hit(s_araddr, CNT_OFF)
                     || addr_hit(s_araddr, STAT_OFF);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        awaddr_q  <= s_awaddr;
        aw_have_q <= 1'b1;
      end
      if (w_take) begin
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_bvalid = bvalid_q;
  assign s_bresp  = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata  = rdata_q;
  assign s_rresp  = rresp_q;

endmodule : ptc_timer

/* File: ptc_pins.sv */
// pin-side model: trigger and capture pin levels
module ptc_pins (
  // clock
  input  wire logic       clk_sys,
  // wanted levels: bit0 pin zero, bit1 pin one, bit2 ext clock
  input  wire logic [2:0] want,
  // pins
  output logic            ext_clock_pin,
  output logic            capture_pin_zero,
  output logic            capture_pin_one
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {ext_clock_pin, capture_pin_one, capture_pin_zero} = 3'h0;
  // levels change just after an edge, like a synchronous source
  always @(posedge clk_sys) begin
    {ext_clock_pin, capture_pin_one, capture_pin_zero} <= want;
  end
endmodule : ptc_pins

/* File: ptc_timer_props.sv */
// port checker for the timer block
module ptc_timer_props (
  // clock, reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins
  input wire logic ext_clock_pin,
  input wire logic pulse_out,
  input wire logic timer_irq_a,
  input wire logic timer_irq_p,
  // bus handshakes
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_wr;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write response missing");
  property p_rd; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read response missing");
  property p_arblk; s_rvalid |-> !s_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while busy");
  property p_bonce; s_bvalid && s_bready |=> !s_bvalid; endproperty
  a_bonce: assert property (p_bonce) else $error("write response repeated");
  property p_irqa; $fell(timer_irq_a) |-> $rose(s_bvalid); endproperty
  a_irqa: assert property (p_irqa) else $error("request a lost");
  property p_irqp; $fell(timer_irq_p) |-> $rose(s_bvalid); endproperty
  a_irqp: assert property (p_irqp) else $error("request p lost");
  property p_pfall;
    $fell(pulse_out) |-> timer_irq_a || s_bvalid || $past(s_bvalid);
  endproperty
  a_pfall: assert property (p_pfall) else $error("pulse ended early");
  property p_prise;
    $rose(pulse_out) |-> s_bvalid || $past(s_bvalid) || $past(ext_clock_pin);
  endproperty
  a_prise: assert property (p_prise) else $error("pulse unprompted");
endmodule : ptc_timer_props

/* File: ptc_timer_tb.sv */
// self-checking bench for the timer block
module ptc_timer_tb
  import ptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  want = 3'h0;
  logic        en = 1'b1;
  logic        ext_clock_pin, capture_pin_zero, capture_pin_one;
  logic        pulse_out, timer_irq_a, timer_irq_p;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, rr;
  logic [31:0] s_rdata, rd, c1;
  logic [31:0] s_wdata = 32'h0;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  int          n_fail = 0, samples_checked = 0, cyc = 0, w;

  ptc_timer ptc_timer_i (.clk_sys, .rst, .clk_en(en), .tick(1'b1),
    .ext_clock_pin, .capture_pin_zero, .capture_pin_one, .pulse_out,
    .timer_irq_a, .timer_irq_p, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready);
  ptc_pins ptc_pins_i (.clk_sys, .want, .ext_clock_pin, .capture_pin_zero,
    .capture_pin_one);

  always #12.5 clk_sys = ~clk_sys;

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_sys);
      ta = ta || (s_awvalid && s_awready);
      tw = tw || (s_wvalid && s_wready);
      @(posedge clk_sys);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end
    do begin
      @(negedge clk_sys);
      tb = s_bvalid;
      @(posedge clk_sys);
    end while (!tb);
    s_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    logic t;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      t = s_arvalid && s_arready;
      @(posedge clk_sys);
    end while (!t);
    s_arvalid <= 1'b0;
    do begin
      @(negedge clk_sys);
      t = s_rvalid;
      rd = s_rdata;
      rr = s_rresp;
      @(posedge clk_sys);
    end while (!t);
    s_rready <= 1'b0;
  endtask : rdr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask : rc

  task automatic pins(input logic [2:0] v);
    @(posedge clk_sys);
    want <= v;
    repeat (4) @(posedge clk_sys);
  endtask : pins

  task automatic t_regs();
    rc(CTRL_OFF, 32'h0);
    rc(CNT_OFF, 32'h0);
    wr(CMPA_OFF, 32'hFFFFFFFF);
    rc(CMPA_OFF, 32'h3FF);
    wr(PER_OFF, 32'hFFFFFFFF);
    rc(PER_OFF, 32'h3FF);
    rdr(8'h14);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    $display("t_regs done");
  endtask : t_regs

  task automatic t_pulse();
    wr(PER_OFF, 32'h2);
    wr(CMPA_OFF, 32'h5);
    wr(CTRL_OFF, 32'h3E);
    w = 0;
    repeat (30) begin
      @(negedge clk_sys);
      if (pulse_out === 1'b1) w++;
    end
    chk(32'(w >= 3 && w <= 7), 32'h1);
    chk({31'h0, timer_irq_a}, 32'h1);
    rc(CTRL_OFF, 32'h2E);
    rdr(CNT_OFF);
    c1 = rd;
    rc(CNT_OFF, c1);
    wr(STAT_OFF, 32'h3);
    wr(CMPA_OFF, 32'h3);
    pins(3'h4);
    repeat (20) @(posedge clk_sys);
    chk({31'h0, timer_irq_a}, 32'h1);
    pins(3'h0);
    wr(STAT_OFF, 32'h3);
    wr(CMPA_OFF, 32'hC8);
    wr(CTRL_OFF, 32'h3E);
    repeat (10) @(posedge clk_sys);
    chk({31'h0, pulse_out}, 32'h1);
    wr(CTRL_OFF, 32'h2C);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, pulse_out, timer_irq_a}, 32'h0);
    $display("t_pulse done");
  endtask : t_pulse

  task automatic t_capt();
    wr(PER_OFF, 32'h0);
    for (int s = 0; s < 3; s++) begin
      for (int a = 0; a < 4; a++) begin
        wr(CTRL_OFF, 32'h11 | (32'(s) << 8) | (32'(a) << 2));
        wr(STAT_OFF, 32'h3);
        pins(3'h1 << s);
        rdr(STAT_OFF);
        chk({31'h0, rd[0]}, {31'h0, (a == 0 || a == 2)});
        wr(STAT_OFF, 32'h3);
        pins(3'h0);
        rdr(STAT_OFF);
        chk({31'h0, rd[0]}, {31'h0, (a == 1 || a == 2)});
      end
    end
    $display("t_capt done");
  endtask : t_capt

  task automatic t_period();
    wr(CTRL_OFF, 32'h0);
    wr(PER_OFF, 32'h3);
    wr(STAT_OFF, 32'h3);
    wr(CTRL_OFF, 32'h1D);
    pins(3'h7);
    pins(3'h0);
    rdr(CNT_OFF);
    chk(32'(rd <= 32'h3), 32'h1);
    rc(STAT_OFF, 32'h2);
    chk({31'h0, timer_irq_p}, 32'h1);
    wr(PER_OFF, 32'h0);
    wr(CTRL_OFF, 32'h0);
    wr(CTRL_OFF, 32'hF1);
    repeat (600) @(posedge clk_sys);
    rdr(CNT_OFF);
    chk(32'(rd >= 32'h258), 32'h1);
    c1 = rd;
    // enable low freezes the counter for 20 cycles
    @(posedge clk_sys);
    en <= 1'b0;
    repeat (20) @(posedge clk_sys);
    en <= 1'b1;
    rdr(CNT_OFF);
    chk(32'(rd > c1 && rd < c1 + 32'hC), 32'h1);
    c1 = rd;
    pins(3'h1);
    rdr(CMPA_OFF);
    chk(32'(rd > c1 && rd < c1 + 32'h14), 32'h1);
    chk({31'h0, pulse_out}, 32'h0);
    $display("t_period done");
  endtask : t_period

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_pulse();
    t_capt();
    t_period();
    test_done();
  end
endmodule : ptc_timer_tb

bind ptc_timer ptc_timer_props ptc_timer_props_i (.*);
